// ===== hw/gdt_pkg.sv
// What this block does
// - serial transfers are taken only while serial_select_n is low
// - hardware variant takes gain, current, mode and threshold from strap inputs
// - charge pump undervoltage is watched always and raises a sticky event
// - sixteen current levels over serial, seven strap levels mapped onto them
// - selected current only during drive window, hold current afterwards
// - overcurrent halves the applied gate current level
// - in half-bridge mode, turn-on waits until the opposite gate monitor reports off
// - serial variant adds programmable digital dead time after the handshake
// - strong pulldown on the opposite gate during the drive window
// - gate voltage checked at window end; mismatch reports gate drive fault
// - a new command ends the running window at once
// - current codes 0 to 3 set the long-window bit, giving 20 us
// - controller may clear the long-window bit; field then sets the window
// - other codes ignore long-window writes; strap variant has no long window
// - any fault pulls the open-drain fault output low
package gdt_pkg;
  localparam int CLK_NS        = 50;
  localparam int WIN0_NS       = 500;
  localparam int WIN1_NS       = 1000;
  localparam int WIN2_NS       = 2000;
  localparam int WIN3_NS       = 4000;
  localparam int LONG_WIN_NS   = 20000;
  localparam int DEAD_STEP_NS  = 50;
  localparam int WIN0_CYC      = (WIN0_NS + CLK_NS - 1) / CLK_NS;
  localparam int WIN1_CYC      = (WIN1_NS + CLK_NS - 1) / CLK_NS;
  localparam int WIN2_CYC      = (WIN2_NS + CLK_NS - 1) / CLK_NS;
  localparam int WIN3_CYC      = (WIN3_NS + CLK_NS - 1) / CLK_NS;
  localparam int LONG_WIN_CYC  = (LONG_WIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEAD_STEP_CYC = (DEAD_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WIN_W         = 9;
  localparam int DEAD_W        = 3;
  localparam int FRAME_BITS    = 16;

  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CFG    = 4'h1;
  localparam logic [3:0] ADDR_MODE   = 4'h2;
  localparam logic [3:0] ADDR_CLEAR  = 4'h3;

  localparam int CFG_LEVEL_LSB = 0;
  localparam int CFG_WIN_LSB   = 4;
  localparam int CFG_LONG_BIT  = 6;
  localparam int CFG_DEAD_LSB  = 7;
  localparam int MODE_IND_LSB  = 0;
  localparam int MODE_GAIN_LSB = 3;
  localparam int MODE_VDS_LSB  = 5;

  localparam logic [3:0] RST_LEVEL     = 4'h0;
  localparam logic [1:0] RST_WIN       = 2'h0;
  localparam logic       RST_LONG      = 1'b1;
  localparam logic [2:0] RST_DEAD      = 3'h0;
  localparam logic [3:0] LOW_LEVEL_MAX = 4'h3;
  localparam logic [2:0] STRAP_INDEP   = 3'h7;

  typedef enum logic [1:0] {GDT_IDLE, GDT_WAIT, GDT_DEAD, GDT_DRIVE} gdt_hb_state_t;

  function automatic logic [WIN_W-1:0] win_cycles(input logic [1:0] field, input logic long_sel);
    if (long_sel) return WIN_W'(LONG_WIN_CYC);
    case (field)
      2'h0:    return WIN_W'(WIN0_CYC);
      2'h1:    return WIN_W'(WIN1_CYC);
      2'h2:    return WIN_W'(WIN2_CYC);
      default: return WIN_W'(WIN3_CYC);
    endcase
  endfunction

  // seven strap levels spread over the sixteen-step range
  function automatic logic [3:0] strap_level(input logic [2:0] code);
    case (code)
      3'h0:    return 4'h0;
      3'h1:    return 4'h2;
      3'h2:    return 4'h5;
      3'h3:    return 4'h7;
      3'h4:    return 4'ha;
      3'h5:    return 4'hc;
      default: return 4'hf;
    endcase
  endfunction
endpackage

// ===== hw/gdt_ser_if.sv
`timescale 1ns/1ps
`default_nettype none
interface gdt_ser_if;
  logic        wr;
  logic [3:0]  addr;
  logic [10:0] wdata;
  logic [10:0] rdata;
  modport ctl  (output wr, output addr, output wdata, input rdata);
  modport regs (input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== hw/gdt_serial.sv
`timescale 1ns/1ps
`default_nettype none
module gdt_serial (
  input  wire logic   sys_clk,
  input  wire logic   rst,
  input  wire logic   serial_select_n,
  input  wire logic   serial_clk,
  input  wire logic   serial_in,
  gdt_ser_if.ctl      bus,
  output logic        serial_out
);
  logic        sclk_q;
  logic [4:0]  cnt;
  logic [14:0] shin;
  logic [9:0]  shout;
  logic        rise;
  logic        fall;

  assign rise = serial_clk & ~sclk_q;
  assign fall = ~serial_clk & sclk_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= serial_clk;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt       <= 5'h0;
      shin      <= 15'h0;
      bus.wr    <= 1'b0;
      bus.addr  <= 4'h0;
      bus.wdata <= 11'h0;
    end else begin
      bus.wr <= 1'b0;
      if (serial_select_n) begin
        cnt <= 5'h0;
      end else if (rise && cnt < 5'(gdt_pkg::FRAME_BITS)) begin
        shin <= {shin[13:0], serial_in};
        cnt  <= cnt + 5'h1;
        if (cnt == 5'h4) begin
          bus.addr <= {shin[2:0], serial_in};
        end
        if (cnt == 5'(gdt_pkg::FRAME_BITS - 1)) begin
          bus.wr    <= ~shin[14];
          bus.wdata <= {shin[9:0], serial_in};
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      serial_out <= 1'b0;
      shout      <= 10'h0;
    end else if (serial_select_n) begin
      serial_out <= 1'b0;
    end else if (fall) begin
      if (cnt == 5'h5) begin
        serial_out <= bus.rdata[10];
        shout      <= bus.rdata[9:0];
      end else begin
        serial_out <= shout[9];
        shout      <= {shout[8:0], 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/gdt_half_bridge.sv
`timescale 1ns/1ps
`default_nettype none
module gdt_half_bridge (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     cmd_h,
  input  wire logic                     cmd_l,
  input  wire logic                     indep,
  input  wire logic                     mon_h,
  input  wire logic                     mon_l,
  input  wire logic [gdt_pkg::WIN_W-1:0] win_len,
  input  wire logic [gdt_pkg::DEAD_W-1:0] dead_len,
  output logic                          gate_h,
  output logic                          gate_l,
  output logic                          strong_h,
  output logic                          strong_l,
  output logic                          full,
  output logic                          fault_evt
);
  gdt_pkg::gdt_hb_state_t     state;
  logic [1:0]                 cmd_q;
  logic [1:0]                 tgt;
  logic [gdt_pkg::WIN_W-1:0]  cnt;
  logic                       th;
  logic                       tl;
  logic                       blocked;

  // both-on in half-bridge mode is treated as off
  assign th      = cmd_h & (indep | ~cmd_l);
  assign tl      = cmd_l & (indep | ~cmd_h);
  assign blocked = ~indep & ((th & (gate_l | mon_l)) | (tl & (gate_h | mon_h)));
  assign full     = (state == gdt_pkg::GDT_DRIVE);
  assign strong_h = full & ~gate_h;
  assign strong_l = full & ~gate_l;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state     <= gdt_pkg::GDT_IDLE;
      cmd_q     <= 2'h0;
      tgt       <= 2'h0;
      cnt       <= '0;
      gate_h    <= 1'b0;
      gate_l    <= 1'b0;
      fault_evt <= 1'b0;
    end else begin
      fault_evt <= 1'b0;
      if ({cmd_h, cmd_l} != cmd_q) begin
        cmd_q <= {cmd_h, cmd_l};
        tgt   <= {th, tl};
        if (blocked) begin
          gate_h <= gate_h & th;
          gate_l <= gate_l & tl;
          state  <= gdt_pkg::GDT_WAIT;
        end else begin
          gate_h <= th;
          gate_l <= tl;
          cnt    <= win_len;
          state  <= gdt_pkg::GDT_DRIVE;
        end
      end else begin
        case (state)
          gdt_pkg::GDT_WAIT: begin
            if (tgt[1] ? ~mon_l : ~mon_h) begin
              if (dead_len == '0) begin
                gate_h <= tgt[1];
                gate_l <= tgt[0];
                cnt    <= win_len;
                state  <= gdt_pkg::GDT_DRIVE;
              end else begin
                cnt   <= gdt_pkg::WIN_W'(dead_len * gdt_pkg::DEAD_STEP_CYC);
                state <= gdt_pkg::GDT_DEAD;
              end
            end
          end
          gdt_pkg::GDT_DEAD: begin
            cnt <= cnt - 1'b1;
            if (cnt == 1) begin
              gate_h <= tgt[1];
              gate_l <= tgt[0];
              cnt    <= win_len;
              state  <= gdt_pkg::GDT_DRIVE;
            end
          end
          gdt_pkg::GDT_DRIVE: begin
            cnt <= cnt - 1'b1;
            if (cnt == 1) begin
              fault_evt <= (mon_h != gate_h) | (mon_l != gate_l);
              state     <= gdt_pkg::GDT_IDLE;
            end
          end
          default: state <= gdt_pkg::GDT_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/gdt_top.sv
`timescale 1ns/1ps
`default_nettype none
module gdt_top #(
  parameter int PHASES = 3
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              serial_variant,
  input  wire logic              serial_select_n,
  input  wire logic              serial_clk,
  input  wire logic              serial_in,
  input  wire logic [1:0]        strap_gain,
  input  wire logic [2:0]        strap_current,
  input  wire logic [2:0]        strap_mode,
  input  wire logic [3:0]        drain_source_threshold_strap,
  input  wire logic [PHASES-1:0] pwm_high,
  input  wire logic [PHASES-1:0] pwm_low,
  input  wire logic [PHASES-1:0] gate_source_monitor_high,
  input  wire logic [PHASES-1:0] gate_source_monitor_low,
  input  wire logic [PHASES-1:0] overcurrent,
  input  wire logic              charge_pump_uv,
  output logic [PHASES-1:0]      gate_high,
  output logic [PHASES-1:0]      gate_low,
  output logic [PHASES-1:0]      strong_pulldown_high,
  output logic [PHASES-1:0]      strong_pulldown_low,
  output logic [PHASES-1:0]      hold_current,
  output logic [3:0]             gate_current_level,
  output logic [1:0]             amp_gain,
  output logic [3:0]             drain_source_threshold,
  output logic [PHASES-1:0]      gate_drive_fault,
  output logic                   charge_pump_uv_flag,
  output logic                   fault_out_n_o,
  output logic                   fault_out_n_oe,
  output logic                   serial_out,
  output logic                   serial_out_oe
);
  if (PHASES < 1 || PHASES > 3) begin : g_bad_phases
    $error("PHASES must be 1 to 3");
  end

  gdt_ser_if bus ();

  logic [3:0]                 level;
  logic [1:0]                 win_field;
  logic                       long_window_select;
  logic [2:0]                 dead_code;
  logic [2:0]                 indep_reg;
  logic [1:0]                 gain_reg;
  logic [3:0]                 vds_reg;
  logic                       strap_done;
  logic [1:0]                 s_gain;
  logic [2:0]                 s_current;
  logic [2:0]                 s_mode;
  logic [3:0]                 s_vds;
  logic [3:0]                 level_eff;
  logic [gdt_pkg::WIN_W-1:0]  win_len;
  logic [gdt_pkg::DEAD_W-1:0] dead_len;
  logic [PHASES-1:0]          indep;
  logic [PHASES-1:0]          hb_gh;
  logic [PHASES-1:0]          hb_gl;
  logic [PHASES-1:0]          hb_sh;
  logic [PHASES-1:0]          hb_sl;
  logic [PHASES-1:0]          hb_full;
  logic [PHASES-1:0]          hb_fault;
  logic                       clear;
  logic [3:0]                 new_level;

  gdt_serial u_serial (
    .sys_clk         (sys_clk),
    .rst             (rst),
    .serial_select_n (serial_select_n),
    .serial_clk      (serial_clk),
    .serial_in       (serial_in),
    .bus             (bus.ctl),
    .serial_out      (serial_out)
  );

  // straps taken once after reset release
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strap_done <= 1'b0;
      s_gain     <= 2'h0;
      s_current  <= 3'h0;
      s_mode     <= 3'h0;
      s_vds      <= 4'h0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      s_gain     <= strap_gain;
      s_current  <= strap_current;
      s_mode     <= strap_mode;
      s_vds      <= drain_source_threshold_strap;
    end
  end

  assign new_level = bus.wdata[gdt_pkg::CFG_LEVEL_LSB +: 4];
  assign clear     = serial_variant & bus.wr & (bus.addr == gdt_pkg::ADDR_CLEAR)
                     & bus.wdata[0];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      level              <= gdt_pkg::RST_LEVEL;
      win_field          <= gdt_pkg::RST_WIN;
      long_window_select <= gdt_pkg::RST_LONG;
      dead_code          <= gdt_pkg::RST_DEAD;
    end else if (serial_variant && bus.wr && bus.addr == gdt_pkg::ADDR_CFG) begin
      level     <= new_level;
      win_field <= bus.wdata[gdt_pkg::CFG_WIN_LSB +: 2];
      dead_code <= bus.wdata[gdt_pkg::CFG_DEAD_LSB +: 3];
      if (new_level > gdt_pkg::LOW_LEVEL_MAX) begin
        long_window_select <= 1'b0;
      end else if (level > gdt_pkg::LOW_LEVEL_MAX) begin
        long_window_select <= 1'b1;
      end else begin
        long_window_select <= bus.wdata[gdt_pkg::CFG_LONG_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      indep_reg <= 3'h0;
      gain_reg  <= 2'h0;
      vds_reg   <= 4'h0;
    end else if (serial_variant && bus.wr && bus.addr == gdt_pkg::ADDR_MODE) begin
      indep_reg <= bus.wdata[gdt_pkg::MODE_IND_LSB +: 3];
      gain_reg  <= bus.wdata[gdt_pkg::MODE_GAIN_LSB +: 2];
      vds_reg   <= bus.wdata[gdt_pkg::MODE_VDS_LSB +: 4];
    end
  end

  assign level_eff = serial_variant ? level : gdt_pkg::strap_level(s_current);
  assign win_len   = gdt_pkg::win_cycles(serial_variant ? win_field : gdt_pkg::RST_WIN,
                                         serial_variant & long_window_select);
  assign dead_len  = serial_variant ? dead_code : '0;

  always_comb begin
    bus.rdata = 11'h0;
    case (bus.addr)
      gdt_pkg::ADDR_STATUS: begin
        bus.rdata[PHASES-1:0] = gate_drive_fault;
        bus.rdata[3]          = charge_pump_uv_flag;
        bus.rdata[4]          = fault_out_n_oe;
      end
      gdt_pkg::ADDR_CFG: begin
        bus.rdata[gdt_pkg::CFG_LEVEL_LSB +: 4] = level;
        bus.rdata[gdt_pkg::CFG_WIN_LSB +: 2]   = win_field;
        bus.rdata[gdt_pkg::CFG_LONG_BIT]       = long_window_select;
        bus.rdata[gdt_pkg::CFG_DEAD_LSB +: 3]  = dead_code;
      end
      gdt_pkg::ADDR_MODE: begin
        bus.rdata[gdt_pkg::MODE_IND_LSB +: 3]  = indep_reg;
        bus.rdata[gdt_pkg::MODE_GAIN_LSB +: 2] = gain_reg;
        bus.rdata[gdt_pkg::MODE_VDS_LSB +: 4]  = vds_reg;
      end
      default: bus.rdata = 11'h0;
    endcase
  end

  genvar p;
  generate
    for (p = 0; p < PHASES; p++) begin : g_phase
      assign indep[p] = serial_variant ? indep_reg[p] : (s_mode == gdt_pkg::STRAP_INDEP);
      gdt_half_bridge u_hb (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .cmd_h     (pwm_high[p]),
        .cmd_l     (pwm_low[p]),
        .indep     (indep[p]),
        .mon_h     (gate_source_monitor_high[p]),
        .mon_l     (gate_source_monitor_low[p]),
        .win_len   (win_len),
        .dead_len  (dead_len),
        .gate_h    (hb_gh[p]),
        .gate_l    (hb_gl[p]),
        .strong_h  (hb_sh[p]),
        .strong_l  (hb_sl[p]),
        .full      (hb_full[p]),
        .fault_evt (hb_fault[p])
      );
      // set wins over clear
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          gate_drive_fault[p] <= 1'b0;
        end else if (hb_fault[p]) begin
          gate_drive_fault[p] <= 1'b1;
        end else if (clear) begin
          gate_drive_fault[p] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      charge_pump_uv_flag <= 1'b0;
    end else if (charge_pump_uv) begin
      charge_pump_uv_flag <= 1'b1;
    end else if (clear) begin
      charge_pump_uv_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gate_high            <= '0;
      gate_low             <= '0;
      strong_pulldown_high <= '0;
      strong_pulldown_low  <= '0;
      hold_current         <= '0;
      gate_current_level   <= gdt_pkg::RST_LEVEL;
      amp_gain             <= 2'h0;
      drain_source_threshold <= 4'h0;
      fault_out_n_o        <= 1'b0;
      fault_out_n_oe       <= 1'b0;
      serial_out_oe        <= 1'b0;
    end else begin
      gate_high            <= hb_gh;
      gate_low             <= hb_gl;
      strong_pulldown_high <= hb_sh;
      strong_pulldown_low  <= hb_sl;
      hold_current         <= ~hb_full;
      gate_current_level   <= (|overcurrent) ? {1'b0, level_eff[3:1]} : level_eff;
      amp_gain             <= serial_variant ? gain_reg : s_gain;
      drain_source_threshold <= serial_variant ? vds_reg : s_vds;
      fault_out_n_o        <= 1'b0;
      fault_out_n_oe       <= (|gate_drive_fault) | charge_pump_uv_flag | charge_pump_uv;
      serial_out_oe        <= serial_variant & ~serial_select_n;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/gdt_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module gdt_top_props #(
  parameter int PHASES = 3
) (
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              serial_variant,
  input wire logic              serial_select_n,
  input wire logic [2:0]        strap_mode,
  input wire logic [PHASES-1:0] pwm_high,
  input wire logic [PHASES-1:0] pwm_low,
  input wire logic [PHASES-1:0] gate_source_monitor_low,
  input wire logic [PHASES-1:0] overcurrent,
  input wire logic              charge_pump_uv,
  input wire logic [PHASES-1:0] gate_high,
  input wire logic [PHASES-1:0] gate_low,
  input wire logic [PHASES-1:0] strong_pulldown_high,
  input wire logic [PHASES-1:0] strong_pulldown_low,
  input wire logic [PHASES-1:0] hold_current,
  input wire logic [3:0]        gate_current_level,
  input wire logic [PHASES-1:0] gate_drive_fault,
  input wire logic              charge_pump_uv_flag,
  input wire logic              fault_out_n_o,
  input wire logic              fault_out_n_oe,
  input wire logic              serial_out_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic hb;
  // half-bridge mode: independent strap code bypasses interlock
  assign hb = serial_variant || (strap_mode != 3'h7);
  sequence both_cmd;
    (pwm_high[0] && pwm_low[0] && hb) [*3];
  endsequence
  sequence oc_held;
    (overcurrent != '0) [*4];
  endsequence
  a_no_shoot: assert property (hb |-> (gate_high & gate_low) == '0)
    else $error("both gates of a phase on");
  a_both_refused: assert property (both_cmd |-> !gate_high[0] && !gate_low[0])
    else $error("conflicting command not refused");
  a_wait_monitor: assert property ($rose(gate_high[0]) |-> !$past(gate_source_monitor_low[0], 2))
    else $error("turn-on while opposite monitor on");
  a_turn_on_window: assert property ($rose(gate_high[0]) |-> !hold_current[0] && strong_pulldown_low[0])
    else $error("drive window not started at turn-on");
  a_pull_opposite: assert property (((strong_pulldown_low & gate_low) | (strong_pulldown_high & gate_high)) == '0)
    else $error("strong pulldown on a driven gate");
  a_level_oc: assert property (oc_held |-> gate_current_level <= 4'h7)
    else $error("current level not reduced on overcurrent");
  a_uv_flag: assert property (charge_pump_uv |-> ##[1:3] charge_pump_uv_flag)
    else $error("undervoltage not flagged");
  a_fault_pin: assert property ((|gate_drive_fault || charge_pump_uv_flag) |=> fault_out_n_oe)
    else $error("fault pin not pulled low");
  a_od_low: assert property (fault_out_n_o == 1'b0)
    else $error("fault pin driven high");
  a_serial_quiet: assert property (serial_out_oe |-> $past(serial_variant && !serial_select_n))
    else $error("serial output driven while deselected");
endmodule
`default_nettype wire

// ===== testbench/gdt_fet_model.sv
`timescale 1ns/1ps
`default_nettype none
module gdt_fet_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [2:0] gate_h,
  input  wire logic [2:0] gate_l,
  input  wire logic [2:0] stuck_low,
  output logic [2:0]      mon_h,
  output logic [2:0]      mon_l
);
  logic [8:0] sh;
  logic [8:0] sl;
  // gate charge of three cycles, well inside any drive window
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sh <= '0;
      sl <= '0;
    end else begin
      sh <= {sh[5:0], gate_h};
      sl <= {sl[5:0], gate_l};
    end
  end
  // stuck_low models a gate that never charges
  assign mon_h = sh[8:6] & ~stuck_low;
  assign mon_l = sl[8:6];
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        sys_clk, rst, serial_variant, serial_select_n, serial_clk, serial_in;
  logic        charge_pump_uv, charge_pump_uv_flag, fault_out_n_o, fault_out_n_oe;
  logic        serial_out, serial_out_oe;
  logic [1:0]  strap_gain, amp_gain;
  logic [2:0]  strap_current, strap_mode, pwm_high, pwm_low, overcurrent, stuck;
  logic [2:0]  mon_h, mon_l, gate_high, gate_low, spd_h, spd_l, hold_current;
  logic [2:0]  gate_drive_fault;
  logic [3:0]  drain_source_threshold_strap, gate_current_level, drain_source_threshold;
  logic [10:0] r;
  logic [15:0] seen;
  logic [15:0] exp_q[$];
  logic [3:0]  lvl_tab [7] = '{4'h0, 4'h2, 4'h5, 4'h7, 4'ha, 4'hc, 4'hf};
  int          num_errors, check_count, d0, d3, w;
  int unsigned seed;
  event        seen_ev;

  gdt_top uut (.sys_clk(sys_clk), .rst(rst), .serial_variant(serial_variant),
    .serial_select_n(serial_select_n), .serial_clk(serial_clk), .serial_in(serial_in),
    .strap_gain(strap_gain), .strap_current(strap_current), .strap_mode(strap_mode),
    .drain_source_threshold_strap(drain_source_threshold_strap), .pwm_high(pwm_high),
    .pwm_low(pwm_low), .gate_source_monitor_high(mon_h), .gate_source_monitor_low(mon_l),
    .overcurrent(overcurrent), .charge_pump_uv(charge_pump_uv), .gate_high(gate_high),
    .gate_low(gate_low), .strong_pulldown_high(spd_h), .strong_pulldown_low(spd_l),
    .hold_current(hold_current), .gate_current_level(gate_current_level),
    .amp_gain(amp_gain), .drain_source_threshold(drain_source_threshold),
    .gate_drive_fault(gate_drive_fault), .charge_pump_uv_flag(charge_pump_uv_flag),
    .fault_out_n_o(fault_out_n_o), .fault_out_n_oe(fault_out_n_oe),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));
  gdt_fet_model fet (.sys_clk(sys_clk), .rst(rst), .gate_h(gate_high), .gate_l(gate_low),
    .stuck_low(stuck), .mon_h(mon_h), .mon_l(mon_l));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task report_and_stop();
    $display("errors %0d of %0d checks", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // observer: oldest note against each posted result
  initial forever begin
    @(seen_ev);
    chk(seen, exp_q.pop_front());
  end
  task expect_val(input logic [15:0] s, input logic [15:0] e);
    exp_q.push_back(e);
    seen = s;
    -> seen_ev;
    #1;
  endtask
  task tmo();
    num_errors++;
    report_and_stop();
  endtask
  task do_reset();
    @(posedge sys_clk) rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  // one frame, msb first; serial_clk halves of five cycles, idle low
  task sio(input logic rw, input logic [3:0] a, input logic [10:0] d, input logic sn,
           output logic [10:0] rd);
    logic [15:0] f;
    f = {rw, a, d};
    rd = '0;
    @(posedge sys_clk) serial_select_n <= sn;
    for (int b = 0; b < 17; b++) begin
      @(posedge sys_clk) serial_clk <= 1'b0;
      if (b < 16) serial_in <= f[15-b];
      repeat (4) @(posedge sys_clk);
      if (b > 4 && b < 16) rd = {rd[9:0], serial_out};
      if (b < 16) begin
        @(posedge sys_clk) serial_clk <= 1'b1;
        repeat (4) @(posedge sys_clk);
      end
    end
    @(posedge sys_clk) serial_select_n <= 1'b1;
    serial_in <= ~serial_in;
    repeat (4) @(posedge sys_clk);
  endtask
  task cfg(input logic [10:0] d);
    sio(1'b0, 4'h1, d, 1'b0, r);
  endtask
  task rd_chk(input logic [3:0] a, input logic [10:0] e);
    sio(1'b1, a, 11'h000, 1'b0, r);
    expect_val(16'(r), 16'(e));
  endtask
  // low to high: delay to gate on, then window length
  task gate_on(output int dly, output int win);
    dly = 0;
    win = 0;
    @(posedge sys_clk) {pwm_high[0], pwm_low[0]} <= 2'b10;
    do begin
      @(posedge sys_clk);
      #1 dly++;
      if (dly > 50) tmo();
    end while (gate_high[0] !== 1'b1);
    while (hold_current[0] !== 1'b1) begin
      @(posedge sys_clk);
      #1 win++;
      if (win > 900) tmo();
    end
    @(posedge sys_clk) {pwm_high[0], pwm_low[0]} <= 2'b01;
    repeat (40) @(posedge sys_clk);
  endtask

  initial begin
    {rst, serial_variant, serial_clk, serial_in, charge_pump_uv} = 5'h10;
    serial_select_n = 1'b1;
    {strap_gain, strap_current, strap_mode, drain_source_threshold_strap} = '0;
    {pwm_high, pwm_low, overcurrent, stuck} = '0;
    seed = $urandom(32'h0000_088c);
    for (int c = 0; c < 7; c++) begin
      @(posedge sys_clk) strap_current <= c[2:0];
      strap_gain <= 2'($urandom);
      drain_source_threshold_strap <= 4'($urandom);
      strap_mode <= 3'($urandom_range(6));
      do_reset();
      expect_val(16'(gate_current_level), 16'(lvl_tab[c]));
      expect_val(16'({amp_gain, drain_source_threshold}),
                 16'({strap_gain, drain_source_threshold_strap}));
    end
    @(posedge sys_clk) {serial_variant, pwm_low[0]} <= 2'b11;
    do_reset();
    for (int l = 0; l < 16; l++) begin
      cfg({7'h00, 4'(l)});
      expect_val(16'(gate_current_level), 16'(l));
    end
    cfg(11'h012);
    rd_chk(4'h1, 11'h052);
    cfg(11'h012);
    rd_chk(4'h1, 11'h012);
    sio(1'b0, 4'h1, 11'h7ff, 1'b1, r);
    rd_chk(4'h1, 11'h012);
    rd_chk(4'h5, 11'h000);
    gate_on(d0, w);
    expect_val(16'(d0), 16'h0007);
    expect_val(16'(w), 16'h0014);
    cfg(11'h192);
    gate_on(d3, w);
    expect_val(16'(d3 - d0), 16'h0003);
    expect_val(16'(w), 16'h0014);
    @(posedge sys_clk) {pwm_high[0], pwm_low[0]} <= 2'b10;
    repeat (12) @(posedge sys_clk);
    pwm_high[0] <= 1'b0;
    repeat (3) @(posedge sys_clk);
    expect_val(16'(gate_high[0]), 16'h0000);
    repeat (40) @(posedge sys_clk);
    pwm_high[0] <= 1'b1;
    pwm_low[0] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    expect_val(16'({gate_high[0], gate_low[0]}), 16'h0000);
    @(posedge sys_clk) {pwm_high[0], pwm_low[0]} <= 2'h0;
    cfg(11'h049);
    rd_chk(4'h1, 11'h009);
    cfg(11'h001);
    rd_chk(4'h1, 11'h041);
    gate_on(d0, w);
    expect_val(16'(w), 16'h0190);
    cfg(11'h008);
    @(posedge sys_clk) overcurrent <= 3'h2;
    repeat (6) @(posedge sys_clk);
    expect_val(16'(gate_current_level), 16'h0004);
    @(posedge sys_clk) overcurrent <= 3'h0;
    repeat (6) @(posedge sys_clk);
    expect_val(16'(gate_current_level), 16'h0008);
    stuck <= 3'h1;
    gate_on(d0, w);
    expect_val(16'(gate_drive_fault[0]), 16'h0001);
    expect_val(16'(fault_out_n_oe), 16'h0001);
    stuck <= 3'h0;
    rd_chk(4'h0, 11'h011);
    sio(1'b0, 4'h3, 11'h001, 1'b0, r);
    rd_chk(4'h0, 11'h000);
    @(posedge sys_clk) charge_pump_uv <= 1'b1;
    repeat (3) @(posedge sys_clk);
    charge_pump_uv <= 1'b0;
    rd_chk(4'h0, 11'h018);
    expect_val(16'(fault_out_n_oe), 16'h0001);
    report_and_stop();
  end
endmodule
bind gdt_top gdt_top_props #(.PHASES(PHASES)) u_props (.sys_clk(sys_clk), .rst(rst),
  .serial_variant(serial_variant), .serial_select_n(serial_select_n),
  .strap_mode(strap_mode), .pwm_high(pwm_high), .pwm_low(pwm_low),
  .gate_source_monitor_low(gate_source_monitor_low), .overcurrent(overcurrent),
  .charge_pump_uv(charge_pump_uv), .gate_high(gate_high), .gate_low(gate_low),
  .strong_pulldown_high(strong_pulldown_high), .strong_pulldown_low(strong_pulldown_low),
  .hold_current(hold_current), .gate_current_level(gate_current_level),
  .gate_drive_fault(gate_drive_fault), .charge_pump_uv_flag(charge_pump_uv_flag),
  .fault_out_n_o(fault_out_n_o), .fault_out_n_oe(fault_out_n_oe),
  .serial_out_oe(serial_out_oe));
`default_nettype wire
